// File: gcmd_pkg.sv
`default_nettype none
package gcmd_pkg;
    // ------------------------------------------------------------
    // register indices on the device-side register port
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_X_ACCEL_OFFSET = 4'h0;
    localparam logic [3:0] IDX_Y_ACCEL_OFFSET = 4'h1;
    localparam logic [3:0] IDX_X_INCLINE_OFFSET = 4'h2;
    localparam logic [3:0] IDX_Y_INCLINE_OFFSET = 4'h3;
    localparam logic [3:0] IDX_ROTATION_OFFSET = 4'h4;
    localparam logic [3:0] IDX_COMMAND = 4'h5;
    localparam logic [3:0] IDX_STATUS = 4'h6;
    localparam logic [3:0] IDX_DAC_DATA = 4'h7;
    localparam int NUM_OFFSETS = 5;
    // ------------------------------------------------------------
    // command bits and field layout
    // ------------------------------------------------------------
    localparam int CMD_AUTONULL = 0;
    localparam int CMD_FACTORY_RESTORE = 1;
    localparam int CMD_DAC_LATCH = 2;
    localparam int CMD_FLASH_UPDATE = 3;
    localparam int CMD_CLEAR_STATUS = 4;
    localparam int CMD_SOFT_RESET = 7;
    localparam int STAT_FLASH_ERR = 2;
    localparam int OFFSET_MSB = 13;
    localparam logic [15:0] OFFSET_RESET = 16'h0000;
    localparam logic [15:0] OFFSET_MASK = 16'h3fff;
    localparam logic [15:0] DAC_RESET = 16'h0000;
    // ------------------------------------------------------------
    // timing: flash update time and reload time
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ = 100;
    localparam int FLASH_UPDATE_MS = 50;
    localparam int FLASH_UPDATE_CYCLES = FLASH_UPDATE_MS * 1000 * CLOCK_MHZ;
    localparam int RELOAD_CYCLES = 4;
    // ------------------------------------------------------------
    // host-side apb register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_ADDR = 8'h04;
    localparam logic [7:0] APB_WDATA = 8'h08;
    localparam logic [7:0] APB_RDATA = 8'h0c;
    localparam logic [7:0] APB_IRQ_STATUS = 8'h10;
    localparam logic [7:0] APB_IRQ_ENABLE = 8'h14;
    localparam logic [7:0] APB_IRQ_CLEAR = 8'h18;
    localparam int HCMD_GO = 0;
    localparam int HCMD_WRITE = 1;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FLASH_ERR = 1;
endpackage : gcmd_pkg
`default_nettype wire

// File: gcmd_if.sv
`timescale 1ns/10ps
`default_nettype none
// register port between host controller and device
interface gcmd_if;
    logic req; // one-cycle access request
    logic wr; // 1 = write
    logic [3:0] addr; // register index
    logic [15:0] wdata;
    logic ack; // one-cycle answer
    logic [15:0] rdata;
    logic busy; // device cannot accept requests
    modport device (input req, input wr, input addr, input wdata,
        output ack, output rdata, output busy);
    modport host (output req, output wr, output addr, output wdata,
        input ack, input rdata, input busy);
endinterface : gcmd_if
`default_nettype wire

// File: gcmd_device.sv
// Overview of operation
// - soft reset reloads registers from flash
// - flash update copies registers, about 50 ms
// - host reads status after flash update time
// - status read clears error; flash refused until
// - host retries flash update after clearing error
// - dac latch copies data; output stable meanwhile
// - host writes dac bytewise then latches; here dac data is written as one 16-bit word
// - autonull loads negated outputs into offsets
// - autonull only at rest, well filtered
// - factory restore zeroes all offset registers
// - accel offsets 14-bit twos complement
// - incline/rotation offsets 14-bit twos complement
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module gcmd_device #(
    parameter int FLASH_CYCLES = gcmd_pkg::FLASH_UPDATE_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    gcmd_if.device bus,
    input wire logic [5*16-1:0] i_raw_data, // raw sensor outputs, 5 words
    input wire logic i_supply_ok, // supply within range for flash write
    output logic [5*16-1:0] o_out_data, // corrected outputs
    output logic [15:0] o_dac_latch, // dac output latch
    output logic o_processor_restart // pulse while reloading
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_FLASH = 2'b01,
        ST_RELOAD = 2'b10
    } state_t;
    state_t state_q, state_d;
    logic [15:0] offset_q [gcmd_pkg::NUM_OFFSETS]; // live offsets
    logic [15:0] flash_q [gcmd_pkg::NUM_OFFSETS]; // nonvolatile copy
    logic [15:0] dac_data_q; // staging register, written as one 16-bit word
    logic [15:0] dac_flash_q;
    logic [15:0] dac_latch_q;
    logic flash_err_q;
    logic [31:0] count_q;
    logic ack_q;
    logic [15:0] rdata_q;
    logic [5*16-1:0] out_q;
    logic restart_q;
    logic busy_q; // registered busy, always equals state_q != ST_RUN
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic acc = bus.req && (state_q == ST_RUN);
    wire logic wr_en = acc && bus.wr;
    wire logic rd_en = acc && !bus.wr;
    wire logic cmd_wr = wr_en && (bus.addr == gcmd_pkg::IDX_COMMAND);
    wire logic do_null = cmd_wr && bus.wdata[gcmd_pkg::CMD_AUTONULL];
    wire logic do_fact = cmd_wr && bus.wdata[gcmd_pkg::CMD_FACTORY_RESTORE];
    wire logic do_latch = cmd_wr && bus.wdata[gcmd_pkg::CMD_DAC_LATCH];
    // flash access refused while error flag stands
    wire logic do_flash = cmd_wr && bus.wdata[gcmd_pkg::CMD_FLASH_UPDATE]
        && !flash_err_q;
    wire logic do_clr = cmd_wr && bus.wdata[gcmd_pkg::CMD_CLEAR_STATUS];
    wire logic do_rst = cmd_wr && bus.wdata[gcmd_pkg::CMD_SOFT_RESET];
    wire logic stat_rd = rd_en && (bus.addr == gcmd_pkg::IDX_STATUS);
    wire logic flash_done = (state_q == ST_FLASH) && (count_q == 32'h0000_0000);
    wire logic flash_fail = flash_done && !i_supply_ok;
    wire logic reload_done = (state_q == ST_RELOAD) && (count_q == 32'h0000_0000);
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (do_rst) begin
                    state_d = ST_RELOAD;
                end else if (do_flash) begin
                    state_d = ST_FLASH;
                end
            end
            ST_FLASH: begin
                if (flash_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_RELOAD: begin
                if (reload_done) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end
    // ------------------------------------------------------------
    // state and timer
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state_q <= ST_RUN;
            count_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            if (state_q == ST_RUN && do_rst) begin
                count_q <= 32'(gcmd_pkg::RELOAD_CYCLES - 1);
            end else if (state_q == ST_RUN && do_flash) begin
                count_q <= 32'(FLASH_CYCLES - 1);
            end else if (count_q != 32'h0000_0000) begin
                count_q <= count_q - 32'h0000_0001;
            end
        end
    end
    // ------------------------------------------------------------
    // offset registers, one generate lane each
    // ------------------------------------------------------------
    for (genvar g = 0; g < gcmd_pkg::NUM_OFFSETS; g++) begin : g_off
        wire logic sel = wr_en && (bus.addr == 4'(g));
        // negate present output, kept to 14 bits
        wire logic [15:0] neg = (16'h0000 - out_q[g*16 +: 16]) & gcmd_pkg::OFFSET_MASK;
        // sign-extend 14-bit offset to output width
        wire logic [15:0] ext = {{2{offset_q[g][gcmd_pkg::OFFSET_MSB]}},
            offset_q[g][gcmd_pkg::OFFSET_MSB:0]};
        always_ff @(posedge i_clock) begin
            if (i_sys_rst) begin
                offset_q[g] <= gcmd_pkg::OFFSET_RESET;
                flash_q[g] <= gcmd_pkg::OFFSET_RESET;
                out_q[g*16 +: 16] <= 16'h0000;
            end else begin
                if (reload_done) begin
                    offset_q[g] <= flash_q[g];
                end else if (do_fact) begin
                    offset_q[g] <= gcmd_pkg::OFFSET_RESET;
                end else if (do_null) begin
                    offset_q[g] <= neg;
                end else if (sel) begin
                    // upper two bits unused, read as zero
                    offset_q[g] <= bus.wdata & gcmd_pkg::OFFSET_MASK;
                end
                if (flash_done && i_supply_ok) begin
                    flash_q[g] <= offset_q[g];
                end
                out_q[g*16 +: 16] <= i_raw_data[g*16 +: 16] + ext;
            end
        end
    end
    // ------------------------------------------------------------
    // dac staging and latch
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            dac_data_q <= gcmd_pkg::DAC_RESET;
            dac_flash_q <= gcmd_pkg::DAC_RESET;
            dac_latch_q <= gcmd_pkg::DAC_RESET;
        end else begin
            // writes only touch staging, latch holds steady
            if (wr_en && bus.addr == gcmd_pkg::IDX_DAC_DATA) begin
                dac_data_q <= bus.wdata;
            end else if (reload_done) begin
                dac_data_q <= dac_flash_q;
            end
            if (do_latch) begin
                dac_latch_q <= dac_data_q;
            end
            if (flash_done && i_supply_ok) begin
                dac_flash_q <= dac_data_q;
            end
        end
    end
    // ------------------------------------------------------------
    // status flag: set beats clear
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            flash_err_q <= 1'b0;
        end else if (flash_fail) begin
            flash_err_q <= 1'b1;
        end else if (stat_rd || do_clr) begin
            flash_err_q <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // read path and answer
    // ------------------------------------------------------------
    wire logic [15:0] rd_mux =
        (bus.addr < 4'(gcmd_pkg::NUM_OFFSETS)) ? offset_q[bus.addr[2:0]] :
        (bus.addr == gcmd_pkg::IDX_STATUS) ? {13'h0000, flash_err_q, 2'b00} :
        (bus.addr == gcmd_pkg::IDX_DAC_DATA) ? dac_data_q : 16'h0000;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            ack_q <= 1'b0;
            rdata_q <= 16'h0000;
            restart_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            ack_q <= acc;
            busy_q <= (state_d != ST_RUN);
            restart_q <= (state_d == ST_RELOAD);
            if (rd_en) begin
                rdata_q <= rd_mux;
            end
        end
    end
    assign bus.ack = ack_q;
    assign bus.rdata = rdata_q;
    assign bus.busy = busy_q;
    assign o_out_data = out_q;
    assign o_dac_latch = dac_latch_q;
    assign o_processor_restart = restart_q;
endmodule : gcmd_device
`default_nettype wire

// File: gcmd_host.sv
`timescale 1ns/10ps
`default_nettype none
module gcmd_host (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    gcmd_if.host link,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [3:0] addr_q; // target register index
    logic [15:0] wdata_q;
    logic [15:0] rdata_q; // last read result
    logic wr_q;
    logic pend_q; // request waiting for device not busy
    logic req_q;
    logic [1:0] irq_stat_q, irq_en_q;
    logic [31:0] prdata_q;
    logic pready_q, irq_q;
    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire logic setup = i_psel && !i_penable && !pready_q;
    wire logic wr = setup && i_pwrite;
    wire logic go = wr && (i_paddr == gcmd_pkg::APB_CMD) && i_pwdata[gcmd_pkg::HCMD_GO];
    wire logic known = (i_paddr <= gcmd_pkg::APB_IRQ_CLEAR) && (i_paddr[1:0] == 2'b00);
    wire logic issue = pend_q && !link.busy && !req_q;
    // completed read of status with error bit set
    wire logic ferr = link.ack && !wr_q && (addr_q == gcmd_pkg::IDX_STATUS)
        && link.rdata[gcmd_pkg::STAT_FLASH_ERR];
    wire logic [1:0] ev = {ferr, link.ack};
    wire logic [31:0] rd_mux =
        (i_paddr == gcmd_pkg::APB_CMD) ? {31'h0000_0000, pend_q || req_q} :
        (i_paddr == gcmd_pkg::APB_ADDR) ? {28'h000_0000, addr_q} :
        (i_paddr == gcmd_pkg::APB_WDATA) ? {16'h0000, wdata_q} :
        (i_paddr == gcmd_pkg::APB_RDATA) ? {16'h0000, rdata_q} :
        (i_paddr == gcmd_pkg::APB_IRQ_STATUS) ? {30'h0000_0000, irq_stat_q} :
        (i_paddr == gcmd_pkg::APB_IRQ_ENABLE) ? {30'h0000_0000, irq_en_q} :
        32'h0000_0000;
    // ------------------------------------------------------------
    // apb slave: no wait state, answer in access cycle
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            pready_q <= setup;
            o_pslverr <= setup && !known;
            if (setup && !i_pwrite) begin
                prdata_q <= rd_mux;
            end
        end
    end
    // ------------------------------------------------------------
    // order registers and device request
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            addr_q <= 4'h0;
            wdata_q <= 16'h0000;
            wr_q <= 1'b0;
            pend_q <= 1'b0;
            req_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            if (wr && i_paddr == gcmd_pkg::APB_ADDR) begin
                addr_q <= i_pwdata[3:0];
            end
            // software writes the dac data as one 16-bit word then latches
            if (wr && i_paddr == gcmd_pkg::APB_WDATA) begin
                wdata_q <= i_pwdata[15:0];
            end
            if (go && !pend_q) begin
                pend_q <= 1'b1;
                wr_q <= i_pwdata[gcmd_pkg::HCMD_WRITE];
            end else if (issue) begin
                pend_q <= 1'b0;
            end
            req_q <= issue;
            if (link.ack && !wr_q) begin
                rdata_q <= link.rdata;
            end
        end
    end
    // ------------------------------------------------------------
    // interrupts: set beats clear
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            irq_stat_q <= 2'b00;
            irq_en_q <= 2'b00;
            irq_q <= 1'b0;
        end else begin
            // flash error event tells software to retry
            irq_stat_q <= ev | (irq_stat_q & ~((wr && i_paddr == gcmd_pkg::APB_IRQ_CLEAR)
                ? i_pwdata[1:0] : 2'b00));
            if (wr && i_paddr == gcmd_pkg::APB_IRQ_ENABLE) begin
                irq_en_q <= i_pwdata[1:0];
            end
            irq_q <= |(irq_stat_q & irq_en_q);
        end
    end
    assign link.req = req_q;
    assign link.wr = wr_q;
    assign link.addr = addr_q;
    assign link.wdata = wdata_q;
    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_irq = irq_q;
endmodule : gcmd_host
`default_nettype wire

// File: gcmd_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// register link checker, watches both ends of gcmd_if
// ------------------------------------------------------------
module gcmd_checker #(
    parameter int FLASH_CYCLES = gcmd_pkg::FLASH_UPDATE_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic req,
    input wire logic wr,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata,
    input wire logic busy
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);
    // decode of what the device really takes
    wire take = req && !busy;
    wire cmd_take = take && wr && (addr == gcmd_pkg::IDX_COMMAND);
    wire flash_take = cmd_take && wdata[gcmd_pkg::CMD_FLASH_UPDATE]
        && !wdata[gcmd_pkg::CMD_SOFT_RESET];
    wire stat_take = take && !wr && (addr == gcmd_pkg::IDX_STATUS);
    wire off_take = take && !wr && (addr <= gcmd_pkg::IDX_ROTATION_OFFSET);
    logic [31:0] busy_cnt_q; // length of the running busy spell
    logic known_clear_q; // flash error surely zero: no busy since a status read
    // helper state; any busy spell may end in an error, so stay pessimistic
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            busy_cnt_q <= 32'h0000_0000;
            known_clear_q <= 1'b1;
        end else begin
            busy_cnt_q <= busy ? busy_cnt_q + 32'h0000_0001 : 32'h0000_0000;
            known_clear_q <= busy ? 1'b0 : (stat_take ? 1'b1 : known_clear_q);
        end
    end
    sequence s_flash_go;
        flash_take && known_clear_q;
    endsequence
    sequence s_busy_spell;
        busy [*2];
    endsequence
    ack_answer_a: assert property (take |=> ack)
        else $error("accepted request got no answer next cycle");
    busy_refuse_a: assert property (req && busy |=> !ack)
        else $error("request during busy was answered");
    ack_cause_a: assert property (ack |-> $past(take))
        else $error("answer without an accepted request");
    flash_start_a: assert property (s_flash_go |=> s_busy_spell)
        else $error("flash update did not make the device busy");
    busy_length_a: assert property ($fell(busy) |-> (busy_cnt_q == FLASH_CYCLES)
        || (busy_cnt_q == gcmd_pkg::RELOAD_CYCLES))
        else $error("busy spell has the wrong length");
    busy_cause_a: assert property ($rose(busy) |-> $past(cmd_take)
        || $past(cmd_take, 2))
        else $error("busy rose without a command");
    status_clear_a: assert property (stat_take && known_clear_q
        |=> ack && !rdata[gcmd_pkg::STAT_FLASH_ERR])
        else $error("flash error seen after it was read");
    offset_width_a: assert property (off_take |=> rdata[15:14] == 2'b00)
        else $error("unused offset bits read nonzero");
    flash_go_c: cover property (s_flash_go);
endmodule : gcmd_checker
`default_nettype wire

// File: global_command_and_offset_cal_tb.sv
`timescale 1ns/10ps
`default_nettype none
module global_command_and_offset_cal_tb;
    localparam int FLASH = 20; // short flash time for simulation
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, supply_ok = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, irq, restart, saw_restart = 1'b0, err_seen;
    logic [79:0] raw = '0, out_data;
    logic [15:0] dac_latch, r;
    int miscompares = 0, num_checks = 0, cycles = 0;
    gcmd_if bus_if ();
    gcmd_host gcmd_host_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .link(bus_if),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_irq(irq));
    gcmd_device #(.FLASH_CYCLES(FLASH)) gcmd_device_inst (.i_clock(i_clock),
        .i_sys_rst(i_sys_rst), .bus(bus_if), .i_raw_data(raw), .i_supply_ok(supply_ok),
        .o_out_data(out_data), .o_dac_latch(dac_latch), .o_processor_restart(restart));
    gcmd_checker #(.FLASH_CYCLES(FLASH)) gcmd_checker_inst (.i_clock(i_clock),
        .i_sys_rst(i_sys_rst), .req(bus_if.req), .wr(bus_if.wr), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .ack(bus_if.ack), .rdata(bus_if.rdata), .busy(bus_if.busy));
    // ------------------------------------------------------------
    // clock, hang guard and reload watcher
    // ------------------------------------------------------------
    initial begin
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles++;
        if (restart === 1'b1) saw_restart <= 1'b1;
        if (cycles > 20000) begin // far beyond the roughly 750 the tests need
            miscompares++;
            print_verdict();
        end
    end
    task print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask : chk
    function automatic logic [15:0] sext(input logic [15:0] v);
        return {{2{v[13]}}, v[13:0]};
    endfunction : sext
    // one apb transfer; held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        // no cycle limit here: only the hang guard ends a wait
        do begin
            @(posedge i_clock);
        end while (pready !== 1'b1);
        q = prdata;
        err_seen = pslverr; // error stands only with pready
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clock); // gap so the next request never reassigns this step
    endtask : apb
    // device access through the controller, polled until the go bit drops
    task dev(input logic w, input logic [3:0] idx, input logic [15:0] v);
        apb(1'b1, gcmd_pkg::APB_ADDR, 32'(idx));
        apb(1'b1, gcmd_pkg::APB_WDATA, 32'(v));
        apb(1'b1, gcmd_pkg::APB_CMD, {30'h0000_0000, w, 1'b1});
        do begin
            apb(1'b0, gcmd_pkg::APB_CMD, 32'h0000_0000);
        end while (q[0] !== 1'b0);
        if (!w) apb(1'b0, gcmd_pkg::APB_RDATA, 32'h0000_0000);
    endtask : dev
    task cmd(input int b);
        dev(1'b1, gcmd_pkg::IDX_COMMAND, 16'h0001 << b);
        while (bus_if.busy !== 1'b0) @(posedge i_clock);
    endtask : cmd
    initial begin
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        @(posedge i_clock);
        for (int i = 0; i < 5; i++) begin
            dev(1'b0, 4'(i), 16'h0000);
            chk("offset reset", 32'h0000_0000, q);
            raw[i*16 +: 16] <= 16'h0010 + 16'(i);
        end
        chk("dac reset", 32'h0000_0000, 32'(dac_latch));
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, 32'(err_seen));
        chk("unmapped data", 32'h0000_0000, q);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            r = 16'hfff0 + 16'(i);
            dev(1'b1, 4'(i), r);
            dev(1'b0, 4'(i), 16'h0000);
            chk("offset mask", 32'(r & 16'h3fff), q);
            chk("out sum", 32'(16'(16'h0010 + 16'(i) + sext(r))), 32'(out_data[i*16 +: 16]));
        end
        $display("test offsets done");
        cmd(gcmd_pkg::CMD_FACTORY_RESTORE);
        cmd(gcmd_pkg::CMD_AUTONULL);
        for (int i = 0; i < 5; i++) begin
            r = 16'h0000 - (16'h0010 + 16'(i));
            dev(1'b0, 4'(i), 16'h0000);
            chk("autonull offset", 32'(r & 16'h3fff), q);
            chk("autonull out", 32'h0000_0000, 32'(out_data[i*16 +: 16]));
        end
        cmd(gcmd_pkg::CMD_FACTORY_RESTORE);
        for (int i = 0; i < 5; i++) begin
            dev(1'b0, 4'(i), 16'h0000);
            chk("restored offset", 32'h0000_0000, q);
            chk("restored out", 32'(16'h0010 + 16'(i)), 32'(out_data[i*16 +: 16]));
        end
        $display("test autonull and restore done");
        dev(1'b1, gcmd_pkg::IDX_DAC_DATA, 16'h00ab);
        chk("dac stable", 32'h0000_0000, 32'(dac_latch));
        dev(1'b1, gcmd_pkg::IDX_DAC_DATA, 16'hcdab);
        chk("dac stable", 32'h0000_0000, 32'(dac_latch));
        cmd(gcmd_pkg::CMD_DAC_LATCH);
        repeat (2) @(posedge i_clock);
        chk("dac latched", 32'h0000_cdab, 32'(dac_latch));
        $display("test dac done");
        dev(1'b1, gcmd_pkg::IDX_X_ACCEL_OFFSET, 16'h0123);
        cmd(gcmd_pkg::CMD_FLASH_UPDATE);
        dev(1'b0, gcmd_pkg::IDX_STATUS, 16'h0000);
        chk("flash ok", 32'h0000_0000, 32'(q[gcmd_pkg::STAT_FLASH_ERR]));
        dev(1'b1, gcmd_pkg::IDX_X_ACCEL_OFFSET, 16'h0456);
        dev(1'b1, gcmd_pkg::IDX_DAC_DATA, 16'h1111);
        cmd(gcmd_pkg::CMD_SOFT_RESET);
        dev(1'b0, gcmd_pkg::IDX_X_ACCEL_OFFSET, 16'h0000);
        chk("reloaded offset", 32'h0000_0123, q);
        chk("restart seen", 32'h0000_0001, 32'(saw_restart));
        cmd(gcmd_pkg::CMD_DAC_LATCH);
        repeat (2) @(posedge i_clock);
        chk("reloaded dac", 32'h0000_cdab, 32'(dac_latch));
        $display("test flash and soft reset done");
        supply_ok <= 1'b0;
        cmd(gcmd_pkg::CMD_FLASH_UPDATE);
        supply_ok <= 1'b1;
        dev(1'b1, gcmd_pkg::IDX_COMMAND, 16'h0008);
        chk("flash refused", 32'h0000_0000, 32'(bus_if.busy));
        dev(1'b0, gcmd_pkg::IDX_STATUS, 16'h0000);
        chk("flash err set", 32'h0000_0001, 32'(q[gcmd_pkg::STAT_FLASH_ERR]));
        dev(1'b0, gcmd_pkg::IDX_STATUS, 16'h0000);
        chk("flash err clear", 32'h0000_0000, 32'(q[gcmd_pkg::STAT_FLASH_ERR]));
        apb(1'b0, gcmd_pkg::APB_IRQ_STATUS, 32'h0000_0000);
        chk("irq status", 32'h0000_0001, 32'(q[gcmd_pkg::IRQ_FLASH_ERR]));
        chk("irq done", 32'h0000_0001, 32'(q[gcmd_pkg::IRQ_DONE]));
        chk("irq masked", 32'h0000_0000, 32'(irq));
        apb(1'b1, gcmd_pkg::APB_IRQ_ENABLE, 32'h0000_0002);
        repeat (2) @(posedge i_clock);
        chk("irq raised", 32'h0000_0001, 32'(irq));
        apb(1'b1, gcmd_pkg::APB_IRQ_CLEAR, 32'h0000_0002);
        repeat (2) @(posedge i_clock);
        chk("irq cleared", 32'h0000_0000, 32'(irq));
        cmd(gcmd_pkg::CMD_FLASH_UPDATE);
        dev(1'b0, gcmd_pkg::IDX_STATUS, 16'h0000);
        chk("retry ok", 32'h0000_0000, 32'(q[gcmd_pkg::STAT_FLASH_ERR]));
        // second failure, this time cleared by the clear command
        supply_ok <= 1'b0;
        cmd(gcmd_pkg::CMD_FLASH_UPDATE);
        supply_ok <= 1'b1;
        cmd(gcmd_pkg::CMD_CLEAR_STATUS);
        dev(1'b0, gcmd_pkg::IDX_STATUS, 16'h0000);
        chk("clear cmd", 32'h0000_0000, 32'(q[gcmd_pkg::STAT_FLASH_ERR]));
        $display("test flash error done");
        print_verdict();
    end
endmodule : global_command_and_offset_cal_tb
`default_nettype wire
